// File: src/dsdr_pkg.sv
// Package for the per-socket DMA register set.
// Assumes one 40 MHz clock domain and a 32-bit Avalon-MM register slave.
package dsdr_pkg;
    // ==========================================================
    // Geometry
    localparam int NUM_SOCKETS = 4;
    localparam logic [31:0] SOCKET_STRIDE = 32'h0000_0080;
    localparam logic [31:0] BASE_LOW_SPEED = 32'hE000_8000;
    localparam logic [31:0] BASE_HOST_PORT = 32'hE001_8000;
    localparam logic [31:0] BASE_USB_EGRESS = 32'hE003_8000;
    localparam logic [31:0] BASE_USB_INGRESS = 32'hE004_8000;
    localparam int SOCK_W = 2;
    // ==========================================================
    // Register offsets inside one socket
    localparam logic [6:0] OFF_CHAIN = 7'h00;
    localparam logic [6:0] OFF_SIZE = 7'h04;
    localparam logic [6:0] OFF_COUNT = 7'h08;
    localparam logic [6:0] OFF_STATUS = 7'h0C;
    localparam logic [6:0] OFF_FLAGS = 7'h10;
    // ==========================================================
    // Field positions
    localparam int LOW_MSB = 31;
    localparam int LOW_LSB = 24;
    localparam int DCNT_MSB = 23;
    localparam int DCNT_LSB = 16;
    localparam int DNUM_MSB = 15;
    localparam int DNUM_LSB = 0;
    localparam int B_GO_EN = 31;
    localparam int B_GO_SUSP = 30;
    localparam int B_UNIT = 29;
    localparam int B_HALT_DONE = 26;
    localparam int B_CONS_EN = 23;
    localparam int B_PROD_EN = 22;
    localparam int B_CLIP = 21;
    localparam int B_ENABLED = 20;
    localparam int B_SUSPENDED = 19;
    // Flag register bits
    localparam int F_DONE = 7;
    localparam int F_SUSP = 5;
    localparam int F_LOW = 2;
    localparam int F_SHORT = 8;
    localparam int FLAG_W = 9;
    // ==========================================================
    // Constants
    localparam logic [15:0] NULL_DSCR = 16'hFFFF;
    localparam logic [31:0] STATUS_RESET = 32'h04E0_0000;
    localparam logic [31:0] STATUS_WMASK = 32'hE4E0_0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [31:0] ONE32 = 32'h0000_0001;
    localparam logic [31:0] UNMAPPED_DATA = 32'hDEAD_BEEF;

    typedef enum logic [1:0] {
        DSDR_IDLE,
        DSDR_LOAD,
        DSDR_ACTIVE,
        DSDR_SUSP
    } dsdr_state_t;
endpackage

// File: src/dsdr_socket_regs.sv
// Per-socket DMA descriptor register set with an Avalon-MM slave.
// Assumes the data core reports descriptor loads and completions synchronously.
//
// Summary of operation
// - Socket register sets repeat at block base plus socket index times 0x80.
// - Block base selects low-speed, host-port, USB egress or USB ingress group.
// - Chain-low flag sets while remaining count is at or below watermark.
// - Remaining count decrements per descriptor and wraps from zero to 255.
// - The null descriptor number stops the socket; the remaining count never does.
// - Sixteen-bit active descriptor field; all ones means none available.
// - Transfer size in bytes or descriptors; zero means unlimited.
// - Bytes past the size in the final buffer still reach the core unless the clip bit is set.
// - Nonzero size reached or passed by count sets transfer-done flag.
// - With halt-on-done, reaching size also suspends and sets suspend flag.
// - Transfer count advances only when a descriptor completes.
// - Short-buffer suspension over-counts by one buffer or its bytes.
// - Unit bit picks descriptor counting or byte counting, empties included.
// - Suspended socket resumes only on suspend request falling one to zero.
// - Enable rising reloads the active descriptor, ignoring held values.
`timescale 1ns/1ps
module dsdr_socket_regs
    import dsdr_pkg::*;
#(
    parameter logic [31:0] BLOCK_BASE = BASE_USB_EGRESS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic [SOCK_W-1:0] core_socket,
    input wire logic core_load_done,
    input wire logic [15:0] core_dscr_number,
    input wire logic core_dscr_complete,
    input wire logic [15:0] core_next_dscr,
    input wire logic [31:0] core_byte_count,
    input wire logic core_short_buffer,
    output logic [NUM_SOCKETS-1:0] sock_load_req,
    output logic [NUM_SOCKETS-1:0] sock_active,
    output logic [NUM_SOCKETS-1:0] sock_clip_en,
    output logic [NUM_SOCKETS-1:0] sock_cons_ev_en,
    output logic [NUM_SOCKETS-1:0] sock_prod_ev_en,
    output logic [NUM_SOCKETS-1:0] sock_done
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [NUM_SOCKETS-1:0][31:0] chain;
        logic [NUM_SOCKETS-1:0][31:0] size;
        logic [NUM_SOCKETS-1:0][31:0] count;
        logic [NUM_SOCKETS-1:0][31:0] ctrl;
        logic [NUM_SOCKETS-1:0][FLAG_W-1:0] flags;
        dsdr_state_t [NUM_SOCKETS-1:0] st;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] resp;
    } dsdr_regs_t;

    dsdr_regs_t state_q;
    dsdr_regs_t state_d;

    // ==========================================================
    // Decode helpers
    function automatic logic [31:0] dsdr_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic dsdr_hit(input logic [31:0] addr);
        logic [31:0] rel;
        rel = addr - BLOCK_BASE;
        return (addr >= BLOCK_BASE) &&
               (rel < SOCKET_STRIDE * NUM_SOCKETS) &&
               (rel[1:0] == 2'b00);
    endfunction

    function automatic logic dsdr_known(input logic [6:0] off);
        return (off == OFF_CHAIN) || (off == OFF_SIZE) || (off == OFF_COUNT) ||
               (off == OFF_STATUS) || (off == OFF_FLAGS);
    endfunction

    logic [31:0] rel_addr;
    logic [SOCK_W-1:0] acc_sock;
    logic [6:0] acc_off;
    logic in_range;

    always_comb begin
        rel_addr = avs_address - BLOCK_BASE;
        acc_sock = rel_addr[7 +: SOCK_W];
        acc_off = rel_addr[6:0];
        in_range = dsdr_hit(avs_address);
    end

    // ==========================================================
    // Next state
    always_comb begin
        logic wr_req;
        logic rd_req;
        logic wr_go;
        logic [31:0] new_ctrl;
        logic [31:0] sum;
        logic [7:0] rem;
        logic reached;
        state_d = state_q;
        wr_req = avs_write && !state_q.ack;
        rd_req = avs_read && !state_q.ack;
        // Writes land at the edge where the master sees waitrequest low
        wr_go = avs_write && state_q.ack;
        new_ctrl = ZERO32;
        sum = ZERO32;
        rem = 8'h00;
        reached = 1'b0;
        state_d.ack = (avs_read || avs_write) && !state_q.ack;
        // Read data and response stand until the next request is taken
        if (wr_req || rd_req) begin
            state_d.resp = 2'b00;
        end

        for (int s = 0; s < NUM_SOCKETS; s++) begin
            // Data core side, applied before software so a set beats a clear
            unique case (state_q.st[s])
                DSDR_IDLE: begin
                    if (state_q.ctrl[s][B_GO_EN]) begin
                        state_d.st[s] = DSDR_LOAD;
                    end
                end
                DSDR_LOAD: begin
                    if (core_load_done && core_socket == SOCK_W'(s)) begin
                        state_d.chain[s][DNUM_MSB:DNUM_LSB] = core_dscr_number;
                        state_d.st[s] = (core_dscr_number == NULL_DSCR) ?
                                        DSDR_SUSP : DSDR_ACTIVE;
                    end
                end
                DSDR_ACTIVE: begin
                    if (core_dscr_complete && core_socket == SOCK_W'(s)) begin
                        // Unit selects descriptor or byte counting
                        sum = state_q.count[s] + (state_q.ctrl[s][B_UNIT] ?
                                                  ONE32 : core_byte_count);
                        state_d.count[s] = sum;
                        rem = state_q.chain[s][DCNT_MSB:DCNT_LSB] - 8'h01;
                        state_d.chain[s][DCNT_MSB:DCNT_LSB] = rem;
                        state_d.chain[s][DNUM_MSB:DNUM_LSB] = core_next_dscr;
                        reached = (state_q.size[s] != ZERO32) &&
                                  (sum >= state_q.size[s]);
                        if (reached) begin
                            state_d.flags[s][F_DONE] = 1'b1;
                        end
                        if (rem <= state_q.chain[s][LOW_MSB:LOW_LSB]) begin
                            state_d.flags[s][F_LOW] = 1'b1;
                        end
                        if (core_short_buffer) begin
                            state_d.flags[s][F_SHORT] = 1'b1;
                            state_d.flags[s][F_SUSP] = 1'b1;
                            state_d.st[s] = DSDR_SUSP;
                        end else if (reached && state_q.ctrl[s][B_HALT_DONE]) begin
                            state_d.flags[s][F_SUSP] = 1'b1;
                            state_d.st[s] = DSDR_SUSP;
                        end else if (state_q.ctrl[s][B_GO_SUSP]) begin
                            state_d.flags[s][F_SUSP] = 1'b1;
                            state_d.st[s] = DSDR_SUSP;
                        end else if (core_next_dscr == NULL_DSCR) begin
                            // Only the null descriptor ends the chain
                            state_d.st[s] = DSDR_SUSP;
                        end
                    end
                end
                DSDR_SUSP: begin
                end
            endcase
            if (!state_q.ctrl[s][B_GO_EN]) begin
                state_d.st[s] = DSDR_IDLE;
                state_d.flags[s] = '0;
            end
        end

        // Software side
        if (in_range && wr_go) begin
            unique case (acc_off)
                OFF_CHAIN: begin
                    state_d.chain[acc_sock] = dsdr_merge(state_q.chain[acc_sock],
                                                         avs_writedata,
                                                         avs_byteenable);
                end
                OFF_SIZE: begin
                    state_d.size[acc_sock] = dsdr_merge(state_q.size[acc_sock],
                                                        avs_writedata, avs_byteenable);
                end
                OFF_COUNT: begin
                    state_d.count[acc_sock] = dsdr_merge(state_q.count[acc_sock],
                                                         avs_writedata, avs_byteenable);
                end
                OFF_STATUS: begin
                    new_ctrl = dsdr_merge(state_q.ctrl[acc_sock], avs_writedata,
                                          avs_byteenable) & STATUS_WMASK;
                    state_d.ctrl[acc_sock] = new_ctrl;
                    // Resume only on a one-to-zero suspend request edge
                    if (state_q.ctrl[acc_sock][B_GO_SUSP] && !new_ctrl[B_GO_SUSP] &&
                        state_q.st[acc_sock] == DSDR_SUSP && new_ctrl[B_GO_EN]) begin
                        state_d.st[acc_sock] =
                            (state_q.chain[acc_sock][DNUM_MSB:DNUM_LSB] == NULL_DSCR) ?
                            DSDR_SUSP : DSDR_LOAD;
                    end
                    // Enable rising forces a fresh descriptor fetch
                    if (!state_q.ctrl[acc_sock][B_GO_EN] && new_ctrl[B_GO_EN]) begin
                        state_d.st[acc_sock] = DSDR_LOAD;
                    end
                end
                OFF_FLAGS: begin
                    // Write one to clear; a same-cycle hardware set survives
                    for (int f = 0; f < FLAG_W; f++) begin
                        if (avs_writedata[f] && !(state_d.flags[acc_sock][f] &&
                                                  !state_q.flags[acc_sock][f])) begin
                            state_d.flags[acc_sock][f] = 1'b0;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // Refusal is decided in the wait cycle so it stands at the answering edge
        if (wr_req && !(in_range && dsdr_known(acc_off))) begin
            state_d.resp = 2'b11;
        end

        if (rd_req) begin
            if (in_range) begin
                unique case (acc_off)
                    OFF_CHAIN: state_d.rdata = state_q.chain[acc_sock];
                    OFF_SIZE: state_d.rdata = state_q.size[acc_sock];
                    OFF_COUNT: state_d.rdata = state_q.count[acc_sock];
                    OFF_STATUS: begin
                        state_d.rdata = state_q.ctrl[acc_sock];
                        state_d.rdata[B_ENABLED] = state_q.st[acc_sock] != DSDR_IDLE;
                        state_d.rdata[B_SUSPENDED] = state_q.st[acc_sock] == DSDR_SUSP;
                    end
                    OFF_FLAGS: state_d.rdata = {23'h000000, state_q.flags[acc_sock]};
                    default: begin
                        state_d.rdata = UNMAPPED_DATA;
                        state_d.resp = 2'b11;
                    end
                endcase
            end else begin
                state_d.rdata = UNMAPPED_DATA;
                state_d.resp = 2'b11;
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q.ack <= 1'b0;
            state_q.rdata <= ZERO32;
            state_q.resp <= 2'b00;
            for (int s = 0; s < NUM_SOCKETS; s++) begin
                state_q.ctrl[s] <= STATUS_RESET;
                state_q.flags[s] <= '0;
                state_q.st[s] <= DSDR_IDLE;
                // Chain, size and count keep their contents
                state_q.chain[s] <= state_d.chain[s];
                state_q.size[s] <= state_d.size[s];
                state_q.count[s] <= state_d.count[s];
            end
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Outputs
    assign avs_waitrequest = (avs_read || avs_write) && !state_q.ack;
    assign avs_readdata = state_q.rdata;
    assign avs_response = state_q.resp;

    for (genvar g = 0; g < NUM_SOCKETS; g++) begin : g_out
        assign sock_load_req[g] = state_q.st[g] == DSDR_LOAD;
        assign sock_active[g] = state_q.st[g] == DSDR_ACTIVE;
        // Excess bytes past the size still flow unless clipped
        assign sock_clip_en[g] = state_q.ctrl[g][B_CLIP];
        assign sock_cons_ev_en[g] = state_q.ctrl[g][B_CONS_EN];
        assign sock_prod_ev_en[g] = state_q.ctrl[g][B_PROD_EN];
        assign sock_done[g] = state_q.flags[g][F_DONE];
    end
endmodule

// File: verification/dsdr_core_model.sv
// Data core model: loads and completes descriptors of one socket.
// Assumes the register block shares its clock and reset.
`timescale 1ns/1ps
module dsdr_core_model
    import dsdr_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic arm,
    input wire logic [SOCK_W-1:0] sock,
    input wire logic [15:0] first_num,
    input wire logic [15:0] last_num,
    input wire logic [31:0] bytes,
    input wire logic short_on,
    input wire logic [NUM_SOCKETS-1:0] sock_load_req,
    input wire logic [NUM_SOCKETS-1:0] sock_active,
    output logic [SOCK_W-1:0] core_socket,
    output logic core_load_done,
    output logic [15:0] core_dscr_number,
    output logic core_dscr_complete,
    output logic [15:0] core_next_dscr,
    output logic [31:0] core_byte_count,
    output logic core_short_buffer
);
    // ==========================================================
    // Core behaviour
    logic [15:0] cur;
    int gap;
    // Data fields toggle between pulses so a stale value is never mistaken for news
    always @(posedge clock) begin
        core_load_done <= 1'b0;
        core_dscr_complete <= 1'b0;
        core_socket <= sock;
        core_dscr_number <= ~core_dscr_number;
        core_next_dscr <= ~core_next_dscr;
        core_byte_count <= ~core_byte_count;
        core_short_buffer <= ~core_short_buffer;
        if (!rst_n || arm) begin
            cur <= first_num;
            gap <= 3;
            core_dscr_number <= 16'h0000;
            core_next_dscr <= 16'h0000;
            core_byte_count <= ZERO32;
            core_short_buffer <= 1'b0;
        end else if (gap > 0) begin
            gap <= gap - 1;
        end else if (sock_load_req[sock]) begin
            core_load_done <= 1'b1;
            core_dscr_number <= cur;
            gap <= 3 + $urandom_range(0, 4);
        end else if (sock_active[sock]) begin
            core_dscr_complete <= 1'b1;
            core_next_dscr <= (cur == last_num) ? NULL_DSCR : cur + 16'h0001;
            core_byte_count <= bytes;
            core_short_buffer <= short_on;
            cur <= cur + 16'h0001;
            gap <= 3 + $urandom_range(0, 4);
        end
    end
endmodule

// File: verification/dsdr_socket_regs_monitor.sv
// Protocol and flow checker for the socket register block.
// Assumes one clock domain; watches the block's ports only.
`timescale 1ns/1ps
module dsdr_socket_regs_monitor
    import dsdr_pkg::*;
#(
    parameter logic [31:0] BLOCK_BASE = BASE_USB_EGRESS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [31:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    input wire logic core_load_done,
    input wire logic core_dscr_complete,
    input wire logic [NUM_SOCKETS-1:0] sock_active,
    input wire logic [NUM_SOCKETS-1:0] sock_clip_en,
    input wire logic [NUM_SOCKETS-1:0] sock_cons_ev_en,
    input wire logic [NUM_SOCKETS-1:0] sock_prod_ev_en,
    input wire logic [NUM_SOCKETS-1:0] sock_done
);
    // ==========================================================
    // Decode and properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic req;
    logic mapped;
    logic [31:0] rel;
    assign req = avs_read | avs_write;
    assign rel = avs_address - BLOCK_BASE;
    assign mapped = (rel < NUM_SOCKETS * SOCKET_STRIDE) && (rel[6:0] <= OFF_FLAGS)
        && (rel[1:0] == 2'b00);
    sequence s_take;
        req && avs_waitrequest;
    endsequence
    sequence s_end;
        req && !avs_waitrequest;
    endsequence
    a_first_wait: assert property ($rose(req) |-> avs_waitrequest)
        else $error("no wait state on new request");
    a_one_wait: assert property (s_take |=> !avs_waitrequest)
        else $error("more than one wait state");
    a_idle_free: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest without request");
    a_map_okay: assert property (s_end ##0 mapped |-> avs_response == 2'b00)
        else $error("mapped access refused");
    a_unmap_err: assert property (s_end ##0 !mapped |-> avs_response == 2'b11)
        else $error("unmapped access not refused");
    a_unmap_data: assert property (s_end ##0 (avs_read && !mapped)
        |-> avs_readdata == UNMAPPED_DATA)
        else $error("unmapped read data wrong");
    a_read_stands: assert property (!avs_waitrequest |=> $stable(avs_readdata))
        else $error("read data changed without access");
    a_reset_enab: assert property ($rose(rst_n) |-> (&sock_clip_en) && (&sock_cons_ev_en)
        && (&sock_prod_ev_en) && (sock_active == '0))
        else $error("socket enables wrong after reset");
    a_done_cause: assert property ($rose(|sock_done)
        |-> $past(core_dscr_complete) || $past(core_dscr_complete, 2))
        else $error("done without descriptor completion");
    a_active_load: assert property ($rose(|sock_active)
        |-> $past(core_load_done) || $past(core_load_done, 2))
        else $error("socket active without descriptor load");
endmodule
bind dsdr_socket_regs dsdr_socket_regs_monitor #(.BLOCK_BASE(BLOCK_BASE)) u_mon (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .core_load_done(core_load_done),
    .core_dscr_complete(core_dscr_complete), .sock_active(sock_active),
    .sock_clip_en(sock_clip_en), .sock_cons_ev_en(sock_cons_ev_en),
    .sock_prod_ev_en(sock_prod_ev_en), .sock_done(sock_done)
);

// File: verification/dsdr_socket_regs_test.sv
// Self-checking bench: reset values, decode, byte lanes, descriptor flows.
// Assumes the core model serves the socket selected by sock.
`timescale 1ns/1ps
module dsdr_socket_regs_test
    import dsdr_pkg::*;
;
    // ==========================================================
    // Stimulus and checking
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] avs_address = ZERO32;
    logic [31:0] avs_writedata = ZERO32;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hF;
    logic arm = 1'b0;
    logic short_on = 1'b0;
    logic [SOCK_W-1:0] sock = '0;
    logic [15:0] first_num = 16'h0000;
    logic [15:0] last_num = 16'hFFFE;
    logic [31:0] bytes = ONE32;
    logic [31:0] avs_readdata, core_byte_count, rd, v;
    logic [1:0] avs_response, rsp;
    logic avs_waitrequest, core_load_done, core_dscr_complete, core_short_buffer;
    logic [SOCK_W-1:0] core_socket;
    logic [15:0] core_dscr_number, core_next_dscr;
    logic [NUM_SOCKETS-1:0] sock_load_req, sock_active, sock_clip_en, sock_cons_ev_en;
    logic [NUM_SOCKETS-1:0] sock_prod_ev_en, sock_done;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int b;

    dsdr_socket_regs i_dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .core_socket(core_socket), .core_load_done(core_load_done),
        .core_dscr_number(core_dscr_number), .core_dscr_complete(core_dscr_complete),
        .core_next_dscr(core_next_dscr), .core_byte_count(core_byte_count),
        .core_short_buffer(core_short_buffer), .sock_load_req(sock_load_req),
        .sock_active(sock_active), .sock_clip_en(sock_clip_en),
        .sock_cons_ev_en(sock_cons_ev_en), .sock_prod_ev_en(sock_prod_ev_en),
        .sock_done(sock_done));
    dsdr_core_model u_core (.clock(clock), .rst_n(rst_n), .arm(arm), .sock(sock),
        .first_num(first_num), .last_num(last_num), .bytes(bytes), .short_on(short_on),
        .sock_load_req(sock_load_req), .sock_active(sock_active),
        .core_socket(core_socket), .core_load_done(core_load_done),
        .core_dscr_number(core_dscr_number), .core_dscr_complete(core_dscr_complete),
        .core_next_dscr(core_next_dscr), .core_byte_count(core_byte_count),
        .core_short_buffer(core_short_buffer));

    initial begin
        forever #12.5 clock = ~clock;
    end

    task automatic end_of_test();
        $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] be);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rsp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask

    function automatic logic [31:0] ra(input int s, input logic [6:0] off);
        return BASE_USB_EGRESS + s * SOCKET_STRIDE + {25'h0, off};
    endfunction

    task automatic wr(input int s, input logic [6:0] off, input logic [31:0] d);
        bus(1'b1, ra(s, off), d, 4'hF);
    endtask

    // Retries give the socket time to finish a flow before judging it
    task automatic rchk(input int s, input logic [6:0] off, input logic [31:0] m,
        input logic [31:0] e, input int tries);
        bus(1'b0, ra(s, off), ZERO32, 4'hF);
        for (int n = 0; n < tries && (rd & m) !== e; n++) bus(1'b0, ra(s, off), ZERO32, 4'hF);
        chk(rd & m, e);
    endtask

    initial begin
        b = $urandom(96115);
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        for (int s = 0; s < NUM_SOCKETS; s++) begin
            rchk(s, OFF_STATUS, '1, STATUS_RESET, 0);
            rchk(s, OFF_FLAGS, '1, ZERO32, 0);
        end
        wr(0, 7'h14, ONE32);
        chk({30'h0, rsp}, 32'h3);
        bus(1'b0, BASE_HOST_PORT + {25'h0, OFF_STATUS}, ZERO32, 4'hF);
        chk(rd, UNMAPPED_DATA);
        for (int i = 0; i < 6; i++) begin
            b = $urandom_range(0, 3);
            v = $urandom();
            wr(b, 7'(4 * (i % 3)), v);
            bus(1'b1, ra(b, 7'(4 * (i % 3))), ~v, 4'h5);
            rchk(b, 7'(4 * (i % 3)), '1, {v[31:24], ~v[23:16], v[15:8], ~v[7:0]}, 0);
        end
        // Descriptor units with halt on done at the exact size
        sock <= 2'd1;
        first_num <= 16'h0010;
        arm <= 1'b1;
        wr(1, OFF_CHAIN, 32'h0204_0010);
        wr(1, OFF_SIZE, 32'h3);
        wr(1, OFF_COUNT, ZERO32);
        arm <= 1'b0;
        wr(1, OFF_STATUS, 32'hA4E0_0000);
        rchk(1, OFF_STATUS, 32'h0008_0000, 32'h0008_0000, 200);
        rchk(1, OFF_COUNT, '1, 32'h3, 0);
        rchk(1, OFF_FLAGS, 32'h1A4, 32'h0A4, 0);
        rchk(1, OFF_CHAIN, '1, 32'h0201_0013, 0);
        // Byte units, size passed, chain ends on the null number
        b = $urandom_range(2, 4096);
        sock <= 2'd2;
        first_num <= 16'h0005;
        last_num <= 16'h0006;
        bytes <= b;
        arm <= 1'b1;
        wr(2, OFF_CHAIN, 32'h1001_0005);
        wr(2, OFF_SIZE, 2 * b - 1);
        wr(2, OFF_COUNT, ZERO32);
        arm <= 1'b0;
        wr(2, OFF_STATUS, 32'h80E0_0000);
        rchk(2, OFF_CHAIN, '1, 32'h10FF_FFFF, 200);
        rchk(2, OFF_COUNT, '1, 2 * b, 0);
        rchk(2, OFF_FLAGS, 32'h084, 32'h084, 0);
        chk({31'h0, sock_done[2]}, ONE32);
        // Short buffer with unlimited size, then resume by toggling suspend
        sock <= 2'd3;
        first_num <= 16'h0020;
        last_num <= 16'h0021;
        short_on <= 1'b1;
        arm <= 1'b1;
        wr(3, OFF_CHAIN, 32'h0005_0020);
        wr(3, OFF_SIZE, ZERO32);
        wr(3, OFF_COUNT, 32'hA);
        arm <= 1'b0;
        wr(3, OFF_STATUS, 32'hA4E0_0000);
        rchk(3, OFF_FLAGS, 32'h100, 32'h100, 200);
        short_on <= 1'b0;
        rchk(3, OFF_COUNT, '1, 32'hB, 0);
        rchk(3, OFF_FLAGS, 32'h080, ZERO32, 0);
        wr(3, OFF_FLAGS, 32'h1FF);
        wr(3, OFF_STATUS, 32'hE4E0_0000);
        chk({31'h0, sock_active[3]}, ZERO32);
        wr(3, OFF_STATUS, 32'hA4E0_0000);
        rchk(3, OFF_CHAIN, 32'hFFFF, 32'hFFFF, 200);
        rchk(3, OFF_COUNT, '1, 32'hC, 0);
        end_of_test();
    end
endmodule
